// >>> include/pgts_consts.vh
// register offsets, field positions and factory default images for the pg tree selector
`ifndef PGTS_CONSTS_VH
`define PGTS_CONSTS_VH

// printed offsets are not multiples of four: these are word indices
`define PGTS_IDX_OUT4_RAIL 8'ha6
`define PGTS_IDX_OUT4_PIN 8'ha7
`define PGTS_IDX_OUT2_RAIL 8'ha8
`define PGTS_IDX_OUT2_PIN 8'ha9

// rail select fields
`define PGTS_RAIL_LO 0
`define PGTS_RAIL_HI 5
`define PGTS_BIT_LINREG_A2 7

// pin/ldo select fields
`define PGTS_BIT_LINREG_A3 0
`define PGTS_BIT_TERM 3
`define PGTS_PIN_LO 4
`define PGTS_PIN_HI 7

// factory image defaults
`define PGTS_DEF_OUT4_RAIL 8'hc0
`define PGTS_DEF_OUT4_PIN 8'hcf
`define PGTS_DEF_OUT2_RAIL 8'hdf
`define PGTS_DEF_OUT2_PIN 8'hdf

// bus answer
`define PGTS_UNMAPPED_DATA 32'h00000000
`define PGTS_DATA_W 8

`endif

// >>> rtl/pgts_top.v
// power-good tree selection for output four and output two
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
`include "pgts_consts.vh"

module pgts_top (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // factory image, sampled after reset release
  input wire [7:0] otp_out4_rail,
  input wire [7:0] otp_out4_pin,
  input wire [7:0] otp_out2_rail,
  input wire [7:0] otp_out2_pin,
  input wire otp_valid,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // contributors, asynchronous to clk
  input wire [5:0] rail_pg,
  input wire linreg_a2_pg,
  input wire linreg_a3_pg,
  input wire termination_pg,
  input wire enable_input_1,
  input wire enable_input_2,
  input wire enable_input_4,
  input wire enable_input_5,
  // power-good outputs
  output reg pg_output_four,
  output reg pg_output_two
);

  // contributor vector: six rails, linreg_a2, linreg_a3, termination, four enable pins
  localparam NRAIL = 6;
  localparam NPIN = 4;
  localparam NIN = NRAIL + 3 + NPIN;

  // positions on the contributor vector
  localparam IX_RAIL_LO = 0;
  localparam IX_RAIL_HI = NRAIL - 1;
  localparam IX_A2 = NRAIL;
  localparam IX_A3 = NRAIL + 1;
  localparam IX_TERM = NRAIL + 2;
  localparam IX_PIN_LO = NRAIL + 3;
  localparam IX_PIN_HI = NIN - 1;

  wire [NIN-1:0] raw_in;
  wire [NIN-1:0] filt_vec;

  // pin order 5,4,2,1 matches mask bits 7..4
  assign raw_in = {enable_input_5, enable_input_4, enable_input_2, enable_input_1,
                   termination_pg, linreg_a3_pg, linreg_a2_pg, rail_pg};

  // synchroniser: three stages per input
  // a change is accepted only once stages two and three agree,
  // so a level caught mid-transition never reaches the trees
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg filt_q;

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          filt_q <= 1'b0;
        end else begin
          s1_q <= raw_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // set when both agree high, clear when both agree low
          filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
        end
      end

      assign filt_vec[gi] = filt_q;
    end
  endgenerate

  // named views of the filtered contributors
  wire [NRAIL-1:0] rail_s;
  wire a2_s;
  wire a3_s;
  wire term_s;
  wire [NPIN-1:0] pins_s;

  assign rail_s = filt_vec[IX_RAIL_HI:IX_RAIL_LO];
  assign a2_s = filt_vec[IX_A2];
  assign a3_s = filt_vec[IX_A3];
  assign term_s = filt_vec[IX_TERM];
  assign pins_s = filt_vec[IX_PIN_HI:IX_PIN_LO];

  // mask registers
  reg [7:0] out4_rail_q, out4_pin_q, out2_rail_q, out2_pin_q;
  reg loaded_q;

  function is_idx;
    input [7:0] addr;
    input [7:0] idx;
    begin
      is_idx = (addr == idx);
    end
  endfunction

  // write lands at the edge where the master sees waitrequest low,
  // never at the edge the request is first taken
  wire wr_go;
  assign wr_go = avs_write & ~avs_waitrequest & loaded_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out4_rail_q <= `PGTS_DEF_OUT4_RAIL;
      out4_pin_q <= `PGTS_DEF_OUT4_PIN;
      out2_rail_q <= `PGTS_DEF_OUT2_RAIL;
      out2_pin_q <= `PGTS_DEF_OUT2_PIN;
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      // factory image copied once after release
      if (otp_valid) begin
        out4_rail_q <= otp_out4_rail;
        out4_pin_q <= otp_out4_pin;
        out2_rail_q <= otp_out2_rail;
        out2_pin_q <= otp_out2_pin;
        loaded_q <= 1'b1;
      end
    end else if (wr_go) begin
      // every bit writable, reserved ones too
      if (is_idx(avs_address, `PGTS_IDX_OUT4_RAIL)) begin
        out4_rail_q <= avs_writedata[7:0];
      end else if (is_idx(avs_address, `PGTS_IDX_OUT4_PIN)) begin
        out4_pin_q <= avs_writedata[7:0];
      end else if (is_idx(avs_address, `PGTS_IDX_OUT2_RAIL)) begin
        out2_rail_q <= avs_writedata[7:0];
      end else if (is_idx(avs_address, `PGTS_IDX_OUT2_PIN)) begin
        out2_pin_q <= avs_writedata[7:0];
      end
    end
  end

  // bus handshake: one wait cycle, answer on the second edge
  reg [7:0] rd_sel;
  always @* begin
    if (is_idx(avs_address, `PGTS_IDX_OUT4_RAIL)) begin
      rd_sel = out4_rail_q;
    end else if (is_idx(avs_address, `PGTS_IDX_OUT4_PIN)) begin
      rd_sel = out4_pin_q;
    end else if (is_idx(avs_address, `PGTS_IDX_OUT2_RAIL)) begin
      rd_sel = out2_rail_q;
    end else if (is_idx(avs_address, `PGTS_IDX_OUT2_PIN)) begin
      rd_sel = out2_pin_q;
    end else begin
      rd_sel = 8'h00;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `PGTS_UNMAPPED_DATA;
    end else begin
      if ((avs_read | avs_write) & avs_waitrequest & loaded_q) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= {24'h000000, rd_sel};
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // exclude vector of one tree, laid out like the contributor vector
  // reserved mask bits (rail bit 6, pin bits 2 and 1) are dropped here
  function [NIN-1:0] excl_vec;
    input [7:0] rail_m;
    input [7:0] pin_m;
    begin
      excl_vec = {pin_m[`PGTS_PIN_HI:`PGTS_PIN_LO],
                  pin_m[`PGTS_BIT_TERM],
                  pin_m[`PGTS_BIT_LINREG_A3],
                  rail_m[`PGTS_BIT_LINREG_A2],
                  rail_m[`PGTS_RAIL_HI:`PGTS_RAIL_LO]};
    end
  endfunction

  // tree: a contributor passes when good or excluded
  function tree_ok;
    input [NIN-1:0] good;
    input [NIN-1:0] excl;
    begin
      tree_ok = &(good | excl);
    end
  endfunction

  // regrouped contributors, same order as the exclude vector
  wire [NIN-1:0] good_vec;
  assign good_vec = {pins_s, term_s, a3_s, a2_s, rail_s};

  // output four: rail mask and pin/ldo mask
  wire [NIN-1:0] excl4;
  assign excl4 = excl_vec(out4_rail_q, out4_pin_q);

  // output two: rail mask and pin/ldo mask
  wire [NIN-1:0] excl2;
  assign excl2 = excl_vec(out2_rail_q, out2_pin_q);

  // tree results before the output flops
  wire ok4;
  wire ok2;
  assign ok4 = tree_ok(good_vec, excl4);
  assign ok2 = tree_ok(good_vec, excl2);

  // outputs held low until the factory image has been copied,
  // so a stale default mask never shows a false good
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pg_output_four <= 1'b0;
      pg_output_two <= 1'b0;
    end else begin
      // output four tree
      pg_output_four <= loaded_q & ok4;
      // output two tree
      pg_output_two <= loaded_q & ok2;
    end
  end

endmodule // pgts_top

// >>> bench/pgts_props.sv
// bus and output assertions for the pg tree selector
`timescale 1ns/10ps
module pgts_props (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // watched ports
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire pg_output_four,
  input wire pg_output_two
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ack_bound: assert property ($rose(avs_read) |-> ##[1:3] !avs_waitrequest)
    else $error("read not answered");
  a_ack_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_ack_needs_req: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (!avs_waitrequest && avs_read &&
    (avs_address < 8'ha6 || avs_address > 8'ha9) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved");
  a_rst_out_low: assert property ($fell(sys_rst) |-> !pg_output_four && !pg_output_two)
    else $error("output good straight after reset");
  a_rst_wait_high: assert property ($fell(sys_rst) |-> avs_waitrequest)
    else $error("waitrequest low after reset");
endmodule // pgts_props
bind pgts_top pgts_props pgts_props_inst (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pg_output_four(pg_output_four), .pg_output_two(pg_output_two));

// >>> bench/pgts_partner.sv
// system-side monitor of the power-good pins
`timescale 1ns/10ps
module pgts_partner (
  // clock
  input wire clk,
  // watched pins
  input wire pg_output_four,
  input wire pg_output_two,
  // sampled levels
  output reg [1:0] seen_q
);
  always @(posedge clk) begin
    seen_q <= {pg_output_two, pg_output_four};
  end
endmodule // pgts_partner

// >>> bench/pgts_top_test.sv
// self-checking bench for the pg tree selector
`timescale 1ns/10ps
module pgts_top_test;
  localparam [31:0] OTP = 32'hc3a55a3c;
  reg clk, sys_rst, avs_read, avs_write;
  reg [7:0] avs_address;
  reg [31:0] avs_writedata, r, mm;
  reg [15:0] c;
  reg e4, e2;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, pg_output_four, pg_output_two;
  wire [1:0] seen_q;
  int n_mismatch = 0, n_checks = 0, k, j;
  pgts_top pgts_top_inst (.clk(clk), .sys_rst(sys_rst), .otp_out4_rail(OTP[7:0]),
    .otp_out4_pin(OTP[15:8]), .otp_out2_rail(OTP[23:16]), .otp_out2_pin(OTP[31:24]),
    .otp_valid(1'b1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rail_pg(c[5:0]), .linreg_a2_pg(c[7]),
    .linreg_a3_pg(c[8]), .termination_pg(c[11]), .enable_input_1(c[12]),
    .enable_input_2(c[13]), .enable_input_4(c[14]), .enable_input_5(c[15]),
    .pg_output_four(pg_output_four), .pg_output_two(pg_output_two));
  pgts_partner pgts_partner_inst (.clk(clk), .pg_output_four(pg_output_four),
    .pg_output_two(pg_output_two), .seen_q(seen_q));
  task close_out;
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input w, input [7:0] a, input [7:0] d);
    int i;
    i = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 40);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i >= 40) begin
      n_mismatch++;
      close_out;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = 0;
    c = 16'hffff;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (j = 0; j < 4; j++) begin
      bus(1'b0, 8'ha6 + j, 8'h00);
      chk(r, OTP[8*j+:8]);
    end
    // unmapped place: write ignored, reads zero
    bus(1'b1, 8'ha5, 8'hff);
    bus(1'b0, 8'ha5, 8'h00);
    chk(r, 32'h0);
    // one contributor bad, excluded from one tree only
    for (k = 0; k < 32; k++) begin
      mm = (k < 16) ? {16'h0, 16'h1 << k} : {16'h1 << (k - 16), 16'h0};
      c <= ~(16'h1 << k[3:0]);
      for (j = 0; j < 4; j++) begin
        bus(1'b1, 8'ha6 + j, mm[8*j+:8]);
        bus(1'b0, 8'ha6 + j, 8'h00);
        chk(r, {24'h0, mm[8*j+:8]});
      end
      repeat (8) @(posedge clk);
      e4 = &(c | 16'h0640 | mm[15:0]);
      e2 = &(c | 16'h0640 | mm[31:16]);
      chk(seen_q, {e2, e4});
    end
    // second reset in mid-run: outputs drop, image reloads and steers the trees
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({pg_output_two, pg_output_four}, 2'b00);
    chk(avs_waitrequest, 1'b1);
    sys_rst <= 1'b0;
    for (j = 0; j < 4; j++) begin
      bus(1'b0, 8'ha6 + j, 8'h00);
      chk(r, OTP[8*j+:8]);
    end
    repeat (8) @(posedge clk);
    e4 = &(c | 16'h0640 | OTP[15:0]);
    e2 = &(c | 16'h0640 | OTP[31:16]);
    chk(seen_q, {e2, e4});
    close_out;
  end
endmodule // pgts_top_test
